// file: uhtr_pkg.sv
/*
  uhtr_pkg: register map, field layout, reset values and token codes
  of the host token/frame register block.
  assumes: 32-bit APB, one aligned word per register.
*/
package uhtr_pkg;

  localparam logic [7:0] ADDR_TARGET_ADDRESS = 8'h00;
  localparam logic [7:0] ADDR_FRAME_LOW      = 8'h04;
  localparam logic [7:0] ADDR_FRAME_HIGH     = 8'h08;
  localparam logic [7:0] ADDR_TOKEN_COMMAND  = 8'h0C;
  localparam logic [7:0] ADDR_SOF_THRESHOLD  = 8'h10;
  localparam logic [7:0] ADDR_TOKEN_STATUS   = 8'h14;

  localparam int LOW_SPEED_BIT   = 7;
  localparam int DEV_ADDR_MSB    = 6;
  localparam int TOKEN_TYPE_LSB  = 4;
  localparam int TOKEN_TYPE_MSB  = 7;
  localparam int TOKEN_EP_MSB    = 3;
  localparam int FRAME_LOW_MSB   = 7;
  localparam int FRAME_HIGH_LSB  = 8;
  localparam int FRAME_HIGH_MSB  = 10;

  localparam logic [7:0]  TARGET_ADDRESS_RESET = 8'h00;
  localparam logic [7:0]  TOKEN_COMMAND_RESET  = 8'h00;
  localparam logic [7:0]  SOF_THRESHOLD_RESET  = 8'h00;
  localparam logic [10:0] FRAME_RESET          = 11'h000;

  localparam logic [3:0] TOKEN_SETUP = 4'hD;
  localparam logic [3:0] TOKEN_IN    = 4'h9;
  localparam logic [3:0] TOKEN_OUT   = 4'h1;

  typedef enum logic [1:0] {
    UHTR_KIND_NONE,
    UHTR_KIND_SETUP,
    UHTR_KIND_IN,
    UHTR_KIND_OUT
  } uhtr_kind_t;

  typedef struct packed {
    logic       start;
    uhtr_kind_t kind;
    logic       low_speed;
    logic [6:0] device_address;
    logic [3:0] endpoint;
  } uhtr_token_t;

  typedef struct packed {
    logic        valid;
    logic [10:0] frame;
  } uhtr_sof_t;

endpackage : uhtr_pkg

// file: uhtr_regs.sv
/*
  uhtr_regs: host token/frame register set behind an APB slave.
  assumes: pclk 100 MHz, presetn async active low, the packet engine
  pulses sof_in.valid per received SOF and token_done per finished token.
*/
//
// Contract
// [R1] low-speed bit selects low speed for next token
// [R2] seven-bit device address held, read and write
// [R3] SOF loads frame bits 7:0 into low register
// [R4] SOF loads frame bits 10:8 into high register
// [R5] unimplemented upper bits read as zero
// [R6] token type codes decode SETUP, IN, OUT
// [R7] software writes only the three defined codes
// [R8] software supplies valid endpoint each token
// [R9] eight-bit threshold register, reset to zero
// [R10] software picks threshold matching packet size
// [R11] software checks busy before next token
// [R12] token write starts one transaction as programmed
module uhtr_regs
  import uhtr_pkg::*;
(
  // clock and reset
  input  wire  logic                  pclk,
  input  wire  logic                  presetn,
  // apb slave
  input  wire  logic                  psel,
  input  wire  logic                  penable,
  input  wire  logic                  pwrite,
  input  wire  logic [7:0]            paddr,
  input  wire  logic [31:0]           pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // packet engine side
  input  wire  uhtr_pkg::uhtr_sof_t   sof_in,
  input  wire  logic                  token_done,
  output uhtr_pkg::uhtr_token_t       token_out,
  output logic                        token_in_progress,
  output logic [7:0]                  sof_threshold_count
);
  import uhtr_pkg::*;

  logic [7:0]  target_address;
  logic [7:0]  token_command;
  logic [10:0] frame;
  uhtr_token_t next_token_out;
  logic [7:0]  next_target_address;
  logic [7:0]  next_token_command;
  logic [7:0]  next_sof_threshold_count;
  logic [10:0] next_frame;
  logic        next_token_in_progress;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  function automatic uhtr_kind_t decode_kind(input logic [3:0] code);
    case (code)
      TOKEN_SETUP: decode_kind = UHTR_KIND_SETUP;     // R6
      TOKEN_IN:    decode_kind = UHTR_KIND_IN;        // R6
      TOKEN_OUT:   decode_kind = UHTR_KIND_OUT;       // R6
      default:     decode_kind = UHTR_KIND_NONE;
    endcase
  endfunction : decode_kind

  logic setup_phase;
  logic wr_en;
  assign setup_phase = psel && !penable;
  // writes land at the access edge, where the master sees pready
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    next_target_address      = target_address;
    next_token_command       = token_command;
    next_sof_threshold_count = sof_threshold_count;
    next_frame               = frame;
    next_token_in_progress   = token_in_progress;
    next_token_out           = token_out;
    next_token_out.start     = 1'b0;
    if (sof_in.valid) begin
      next_frame = sof_in.frame;                      // R3 R4
    end
    if (token_done) begin
      next_token_in_progress = 1'b0;
    end
    if (wr_en) begin
      case (paddr)
        ADDR_TARGET_ADDRESS: begin
          next_target_address = pwdata[7:0];          // R1 R2
        end
        ADDR_SOF_THRESHOLD: begin
          next_sof_threshold_count = pwdata[7:0];     // R9
        end
        ADDR_TOKEN_COMMAND: begin
          next_token_command = pwdata[7:0];
          next_token_in_progress = 1'b1;              // R12
          next_token_out.start = 1'b1;                // R12
          next_token_out.kind = decode_kind(
            pwdata[TOKEN_TYPE_MSB:TOKEN_TYPE_LSB]);   // R6
          next_token_out.endpoint = pwdata[TOKEN_EP_MSB:0];
          next_token_out.low_speed =
            target_address[LOW_SPEED_BIT];            // R1
          next_token_out.device_address =
            target_address[DEV_ADDR_MSB:0];           // R12
        end
        default: begin
        end
      endcase
    end
  end

  // no wait state: answer in the first access cycle
  always_comb begin
    next_pready  = 1'b0;
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (setup_phase) begin
      next_pready = 1'b1;
      case (paddr)
        ADDR_TARGET_ADDRESS: next_prdata = {24'h000000, target_address};
        ADDR_FRAME_LOW:
          next_prdata = {24'h000000, frame[FRAME_LOW_MSB:0]};      // R5
        ADDR_FRAME_HIGH:
          next_prdata = {29'h00000000,
                         frame[FRAME_HIGH_MSB:FRAME_HIGH_LSB]};    // R5
        ADDR_TOKEN_COMMAND: next_prdata = {24'h000000, token_command};
        ADDR_SOF_THRESHOLD:
          next_prdata = {24'h000000, sof_threshold_count};         // R5
        ADDR_TOKEN_STATUS:
          next_prdata = {31'h00000000, token_in_progress};
        default: next_pslverr = 1'b1;
      endcase
      if (pwrite && (paddr == ADDR_FRAME_LOW || paddr == ADDR_FRAME_HIGH
                     || paddr == ADDR_TOKEN_STATUS)) begin
        next_pslverr = 1'b0;
      end
      if (pwrite) begin
        next_prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_address      <= TARGET_ADDRESS_RESET;
      token_command       <= TOKEN_COMMAND_RESET;
      sof_threshold_count <= SOF_THRESHOLD_RESET;
      frame               <= FRAME_RESET;
      token_in_progress   <= 1'b0;
      token_out           <= '0;
      pready              <= 1'b0;
      prdata              <= 32'h00000000;
      pslverr             <= 1'b0;
    end else begin
      target_address      <= next_target_address;
      token_command       <= next_token_command;
      sof_threshold_count <= next_sof_threshold_count;
      frame               <= next_frame;
      token_in_progress   <= next_token_in_progress;
      token_out           <= next_token_out;
      pready              <= next_pready;
      prdata              <= next_prdata;
      pslverr             <= next_pslverr;
    end
  end

  sof_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    sof_in.valid |=> frame == $past(sof_in.frame))      // R3
    else $error("frame not captured on sof");

  frame_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == ADDR_FRAME_HIGH)
      |=> prdata[31:3] == 29'h00000000 && pready)        // R5
    else $error("frame high upper bits not zero");

  low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == ADDR_FRAME_LOW && !sof_in.valid)
      |=> prdata[7:0] == frame[7:0])                     // R3
    else $error("frame low read wrong");

  frame_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == ADDR_FRAME_HIGH && !sof_in.valid)
      |=> prdata[2:0] == frame[10:8])                    // R4
    else $error("frame high read wrong");

  sof_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sof_in.valid |=> $stable(frame))                    // R3
    else $error("frame changed without sof");

  ro_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_FRAME_LOW && !sof_in.valid)
      |=> frame == $past(frame))                         // R3
    else $error("frame written by software");

  token_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TOKEN_COMMAND)
      |=> token_out.start && token_in_progress
          && token_out.endpoint == $past(pwdata[3:0]))   // R12
    else $error("token write did not start");

  token_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TOKEN_COMMAND)
      |=> token_out.low_speed == target_address[7])      // R1
    else $error("token speed mismatch");

  token_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TOKEN_COMMAND && pwdata[7:4] == 4'h9)
      |=> token_out.kind == UHTR_KIND_IN)                // R6
    else $error("in token misdecoded");

  setup_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TOKEN_COMMAND && pwdata[7:4] == TOKEN_SETUP)
      |=> token_out.kind == UHTR_KIND_SETUP)             // R6
    else $error("setup token misdecoded");

  out_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TOKEN_COMMAND && pwdata[7:4] == TOKEN_OUT)
      |=> token_out.kind == UHTR_KIND_OUT)               // R6
    else $error("out token misdecoded");

  token_dev_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TOKEN_COMMAND)
      |=> token_out.device_address == $past(target_address[6:0])) // R12
    else $error("token device address wrong");

  ep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == ADDR_TOKEN_COMMAND)
      |=> $stable(token_out.endpoint))                   // R12
    else $error("endpoint changed without write");

  start_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    token_out.start |-> $past(wr_en && paddr == ADDR_TOKEN_COMMAND)) // R12
    else $error("start without token write");

  busy_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (token_done && !(wr_en && paddr == ADDR_TOKEN_COMMAND))
      |=> !token_in_progress)                            // R12
    else $error("busy not cleared by done");

  busy_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (token_in_progress && !token_done)
      |=> token_in_progress)                             // R12
    else $error("busy dropped without done");

  addr_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == ADDR_TARGET_ADDRESS)
      |=> prdata[7:0] == $past(target_address))          // R1 R2
    else $error("address read wrong");

  addr_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == ADDR_TARGET_ADDRESS)
      |=> prdata[31:8] == 24'h000000)                    // R5
    else $error("address upper bits not zero");

  tok_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == ADDR_TOKEN_COMMAND)
      |=> prdata[31:8] == 24'h000000)                    // R5
    else $error("token upper bits not zero");

  thr_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == ADDR_SOF_THRESHOLD)
      |=> prdata == {24'h000000, $past(sof_threshold_count)}) // R9
    else $error("threshold read wrong");

  ready_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready)
    else $error("no ready after setup");

  no_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_phase |=> !pready)
    else $error("ready without setup");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && paddr > ADDR_TOKEN_STATUS)
      |=> pslverr && pready)                             // R5
    else $error("unmapped address not refused");

  addr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_TARGET_ADDRESS)
      |=> target_address[6:0] == $past(pwdata[6:0]))     // R2
    else $error("device address not stored");

  sof_thr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_SOF_THRESHOLD)
      |=> sof_threshold_count == $past(pwdata[7:0]))     // R9
    else $error("threshold not stored");

  start_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    token_out.start |=> !token_out.start)                // R12
    else $error("start longer than one cycle");

endmodule : uhtr_regs

// file: uhtr_usb_model.sv
/*
  uhtr_usb_model: stand-in for the engine and the bus at the far side.
  assumes: pclk domain; a token start is answered after a few cycles.
*/
module uhtr_usb_model
  import uhtr_pkg::*;
(
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // engine side
  input  wire uhtr_pkg::uhtr_token_t token_out,
  output uhtr_pkg::uhtr_sof_t        sof_in,
  output logic                       token_done
);
  int unsigned wait_cnt;

  initial begin
    sof_in     = '0;
    token_done = 1'b0;
    wait_cnt   = 0;
  end

  // finishes each token five cycles after its start
  always @(posedge pclk) begin
    token_done <= presetn && (wait_cnt == 1);
    if (token_out.start)
      wait_cnt <= 4;
    else if (wait_cnt != 0)
      wait_cnt <= wait_cnt - 1;
  end

  // one-cycle SOF, then the frame lines carry the inverted frame
  task automatic send_sof(input logic [10:0] frame);
    @(posedge pclk);
    sof_in <= '{valid: 1'b1, frame: frame};
    @(posedge pclk);
    sof_in <= '{valid: 1'b0, frame: ~frame};
  endtask : send_sof
endmodule : uhtr_usb_model

// file: tb.sv
/*
  tb: self-checking bench for uhtr_regs over APB.
  assumes: uhtr_pkg and uhtr_usb_model compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uhtr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        token_done, token_in_progress;
  logic [7:0]  paddr, sof_threshold_count;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  uhtr_sof_t   sof_in;
  uhtr_token_t token_out, exp_tok;
  int          errors, num_checks;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  uhtr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sof_in(sof_in),
    .token_done(token_done), .token_out(token_out),
    .token_in_progress(token_in_progress),
    .sof_threshold_count(sof_threshold_count));
  uhtr_usb_model u_usb (.pclk(pclk), .presetn(presetn),
    .token_out(token_out), .sof_in(sof_in), .token_done(token_done));

  task automatic check(input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
    if (n >= 20)
      errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk

  task automatic t_reset();
    for (int a = 0; a <= 20; a += 4)
      rdchk(8'(a), 32'h0);
  endtask : t_reset

  task automatic t_addr();
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rdchk(8'h00, 32'h0000_00FF);
    apb(1'b1, 8'h00, 32'h0000_0080);
    rdchk(8'h00, 32'h0000_0080);
  endtask : t_addr

  task automatic t_frame();
    u_usb.send_sof(11'h5A3);
    rdchk(8'h04, 32'h0000_00A3);
    rdchk(8'h08, 32'h0000_0005);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    u_usb.send_sof(11'h7FF);
    rdchk(8'h04, 32'h0000_00FF);
    rdchk(8'h08, 32'h0000_0007);
  endtask : t_frame

  task automatic t_token();
    logic [3:0]  code [3] = '{TOKEN_SETUP, TOKEN_IN, TOKEN_OUT};
    uhtr_kind_t  kind [3] = '{UHTR_KIND_SETUP, UHTR_KIND_IN, UHTR_KIND_OUT};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h00, {24'h0, i[0], 7'(i * 40 + 9)});
      rdchk(8'h14, 32'h0);
      apb(1'b1, 8'h0C, {24'hFFFFFF, code[i], 4'(i * 5 + 3)});
      @(posedge pclk);
      exp_tok = '{1'b1, kind[i], i[0], 7'(i * 40 + 9), 4'(i * 5 + 3)};
      check({17'h0, token_out}, {17'h0, exp_tok});
      check({31'h0, token_in_progress}, 32'h1);
      rdchk(8'h0C, {24'h0, code[i], 4'(i * 5 + 3)});
      repeat (6) @(posedge pclk);
    end
  endtask : t_token

  task automatic t_misc();
    apb(1'b1, 8'h10, 32'hFFFF_FF4A);
    rdchk(8'h10, 32'h0000_004A);
    check({24'h0, sof_threshold_count}, 32'h0000_004A);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_misc

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_addr();
    t_frame();
    t_token();
    t_misc();
    give_verdict();
  end

  // hang guard, well past the roughly 130 cycles the run needs
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule : tb
